// ### src/ifp_pkg.sv
// Package: register map, field layout and reset values of the request flag block
package ifp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PIN_COUNT   = 8;
  localparam int PRIO_REGS   = 10;
  localparam int FIELD_W     = 4;
  localparam int REG_W       = 16;
  localparam int ADDR_W      = 8;
  localparam int LEVELS_W    = PRIO_REGS * REG_W;

  // ----------------------------------------------------------------
  // Register offsets (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS     = 8'h00;
  localparam logic [7:0] ADDR_PRIO_BASE = 8'h01;
  localparam logic [7:0] ADDR_PRIO_LAST = 8'h0A;
  localparam logic [7:0] ADDR_SENSE     = 8'h0B;
  localparam logic [7:0] ADDR_EDGE      = 8'h0C;
  localparam logic [7:0] ADDR_EVT_STAT  = 8'h0D;
  localparam logic [7:0] ADDR_EVT_CLEAR = 8'h0E;
  localparam logic [7:0] ADDR_EVT_EN    = 8'h0F;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int FLAG_TOP_BIT   = 7;
  localparam int RSVD_LSB       = 8;
  localparam int EDGE_TOP_BIT   = 15;

  // Edge select codes
  localparam logic [1:0] EDGE_FALL  = 2'h0;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_BOTH  = 2'h2;
  localparam logic [1:0] EDGE_NONE  = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PRIO  = 16'h0000;
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [7:0]  RST_SENSE = 8'h00;
  localparam logic [15:0] RST_EDGE  = 16'h0000;
  localparam logic [7:0]  RST_EVT   = 8'h00;
  localparam logic [3:0]  PRIO_OFF  = 4'h0;

endpackage : ifp_pkg

// ### src/ifp_pin_detect.sv
// Module: edge and low level detector for one active-low request pin
`timescale 1ns/10ps
`default_nettype none

module ifp_pin_detect #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Pin and mode
  input  wire logic       pinIn_n,
  input  wire logic [1:0] edgeSel,
  // Detection
  output logic            edgeHit,
  output logic            pinLow
);

  logic prevPin;

  // ----------------------------------------------------------------
  // Previous pin level
  // ----------------------------------------------------------------
  // Idle level at reset so no false edge on release
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      prevPin <= IDLE_LEVEL;
    else
      prevPin <= pinIn_n;
  end

  // Edge decode by selected mode
  always_comb
  begin
    pinLow = ~pinIn_n;
    case (edgeSel)
      ifp_pkg::EDGE_FALL: edgeHit = prevPin & ~pinIn_n; // RL14
      ifp_pkg::EDGE_RISE: edgeHit = ~prevPin & pinIn_n; // RL14
      ifp_pkg::EDGE_BOTH: edgeHit = prevPin ^ pinIn_n;  // RL14
      default:            edgeHit = 1'b0;               // RL14
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_edge_prohibited: assert property ( // RL14
    @(posedge sys_clk) disable iff (!arst_n)
    (edgeSel == ifp_pkg::EDGE_NONE) |-> !edgeHit)
    else $error("edge detected under prohibited setting");

  a_edge_falling: assert property ( // RL14
    @(posedge sys_clk) disable iff (!arst_n)
    (edgeSel == ifp_pkg::EDGE_FALL) && $fell(pinIn_n) |-> edgeHit)
    else $error("falling edge missed");

endmodule : ifp_pin_detect

`default_nettype wire

// ### src/ifp_regs.sv
// Module: external request flags, priority registers and event interrupt
//
// Behaviour
// RL1: Upper eight bits of the flags register read zero, writes ignored.
// RL2: Software writes zero into the reserved upper flag bits.
// RL3: One flag per pin, pin 0 at bit 7 to pin 7 at bit 0, reset zero.
// RL4: A flag sets when the selected sense or edge condition occurs.
// RL5: Writing zero after reading one clears a flag.
// RL6: Level mode: exception taken while pin high clears the flag.
// RL7: Edge modes: exception taken for the pin clears its flag.
// RL8: Transfer start by a pin with clear-inhibit zero clears its flag.
// RL9: Ten readable and writable 16-bit priority registers.
// RL10: Each priority register holds four 4-bit fields, one per source.
// RL11: Field value is an unsigned level, 0 lowest, 15 highest.
// RL12: Software writes zero into unassigned priority fields.
// RL13: All priority bits read and write and reset to zero.
// RL14: Edge select 00 falling, 01 rising, 10 both, 11 prohibited.
// RL15: Level mode requests only while the pin is low.
// RL16: A source at priority level zero is masked.
// RL17: Writing one, or zero without prior read of one, keeps the flag.
`timescale 1ns/10ps
`default_nettype none

module ifp_regs (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // Register port
  input  wire logic [7:0]    regAddr,
  input  wire logic [15:0]   regWdata,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic      [15:0]   regRdata,
  // Request pins, active low
  input  wire logic [7:0]    extRequestPin_n,
  // Exception logic and transfer controller
  input  wire logic [7:0]    excTaken,
  input  wire logic [7:0]    xferStart,
  input  wire logic          xferClearInhibit,
  // Requests and levels to the arbiter
  output logic      [7:0]    pinRequest,
  output logic      [159:0]  priorityLevels,
  // Event interrupt
  output logic               irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] prioReg [ifp_pkg::PRIO_REGS];
  logic [7:0]  pinFlag;      // Indexed by pin number
  logic [7:0]  armed;        // Read as one, ready to clear
  logic [7:0]  senseEdge;    // 1 edge mode, 0 low level mode
  logic [15:0] edgeSelect;
  logic [7:0]  evtStat;
  logic [7:0]  evtEn;

  logic [7:0]  edgeHit;
  logic [7:0]  pinLow;
  logic [7:0]  setVec;
  logic [7:0]  hwClr;
  logic [7:0]  swClr;
  logic [7:0]  flagWord;
  logic [7:0]  prioLive;
  logic [7:0]  next_pinFlag;
  logic [7:0]  next_armed;
  logic [7:0]  next_request;
  logic [15:0] next_rdata;

  logic selFlags;
  logic selPrio;
  logic [3:0] prioIdx;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign selFlags = (regAddr == ifp_pkg::ADDR_FLAGS);
  assign selPrio  = (regAddr >= ifp_pkg::ADDR_PRIO_BASE) &&
                    (regAddr <= ifp_pkg::ADDR_PRIO_LAST);
  assign prioIdx  = 4'(regAddr - ifp_pkg::ADDR_PRIO_BASE);

  // ----------------------------------------------------------------
  // Per-pin detectors
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < ifp_pkg::PIN_COUNT; gi++)
    begin : g_pin
      ifp_pin_detect #(
        .IDLE_LEVEL (1'b1)
      ) u_detect (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pinIn_n (extRequestPin_n[gi]),
        .edgeSel (edgeSelect[ifp_pkg::EDGE_TOP_BIT-2*gi -: 2]),
        .edgeHit (edgeHit[gi]),
        .pinLow  (pinLow[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flag set and clear terms
  // ----------------------------------------------------------------
  // Set and clear conditions per pin; pin n maps to word bit 7-n
  always_comb
  begin
    for (int i = 0; i < ifp_pkg::PIN_COUNT; i++)
    begin
      setVec[i] = senseEdge[i] ? edgeHit[i] : pinLow[i]; // RL4 RL15
      hwClr[i]  = (excTaken[i] & (senseEdge[i] | ~pinLow[i])) // RL6 RL7
                | (xferStart[i] & ~xferClearInhibit);         // RL8
      swClr[i]  = regWr & selFlags & armed[i]
                & ~regWdata[ifp_pkg::FLAG_TOP_BIT-i];         // RL5 RL17
      flagWord[ifp_pkg::FLAG_TOP_BIT-i] = pinFlag[i];         // RL3
    end
  end

  // Set wins over every clear
  assign next_pinFlag = setVec | (pinFlag & ~(hwClr | swClr)); // RL4 RL5

  // Arming follows a read of ones; a write to the flags without a read in the same cycle disarms
  always_comb
  begin
    if (regRd && selFlags)
      next_armed = armed | pinFlag;            // RL5
    else if (regWr && selFlags)
      next_armed = 8'h00;                      // RL17
    else
      next_armed = armed & pinFlag;
  end

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      pinFlag <= ifp_pkg::RST_FLAGS;           // RL3
    else
      pinFlag <= next_pinFlag;
  end

  // Arming of the read-then-clear sequence
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      armed <= ifp_pkg::RST_FLAGS;
    else
      armed <= next_armed;
  end

  // ----------------------------------------------------------------
  // Priority registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int k = 0; k < ifp_pkg::PRIO_REGS; k++)
        prioReg[k] <= ifp_pkg::RST_PRIO;       // RL13
    end
    else if (regWr && selPrio)
      prioReg[prioIdx] <= regWdata;            // RL9 RL10
  end

  // Levels packed for the arbiter, register k at bits 16k+15..16k
  always_comb
  begin
    for (int k = 0; k < ifp_pkg::PRIO_REGS; k++)
      priorityLevels[k*ifp_pkg::REG_W +: ifp_pkg::REG_W] = prioReg[k]; // RL10
  end

  // Pin n uses field 3-(n mod 4) of register n/4; zero masks
  always_comb
  begin
    for (int i = 0; i < ifp_pkg::PIN_COUNT; i++)
      prioLive[i] = prioReg[i/4][(3-(i%4))*ifp_pkg::FIELD_W +: ifp_pkg::FIELD_W]
                    != ifp_pkg::PRIO_OFF;      // RL11 RL16
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      senseEdge <= ifp_pkg::RST_SENSE;
    else if (regWr && regAddr == ifp_pkg::ADDR_SENSE)
      senseEdge <= regWdata[7:0];
  end

  // Edge select, pin 0 at bits 15-14 down to pin 7 at bits 1-0
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      edgeSelect <= ifp_pkg::RST_EDGE;
    else if (regWr && regAddr == ifp_pkg::ADDR_EDGE)
      edgeSelect <= regWdata;                  // RL14
  end

  // ----------------------------------------------------------------
  // Requests to the arbiter
  // ----------------------------------------------------------------
  // Level mode follows the pin; edge mode holds the latched flag
  always_comb
  begin
    for (int i = 0; i < ifp_pkg::PIN_COUNT; i++)
      next_request[i] = (senseEdge[i] ? pinFlag[i] : pinLow[i]) // RL15
                        & prioLive[i];                          // RL16
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      pinRequest <= 8'h00;
    else
      pinRequest <= next_request;
  end

  // ----------------------------------------------------------------
  // Event interrupt
  // ----------------------------------------------------------------
  // Sticky event per pin when its flag rises; set beats clear
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      evtStat <= ifp_pkg::RST_EVT;
    else if (regWr && regAddr == ifp_pkg::ADDR_EVT_CLEAR)
      evtStat <= (evtStat & ~regWdata[7:0]) | (next_pinFlag & ~pinFlag);
    else
      evtStat <= evtStat | (next_pinFlag & ~pinFlag);
  end

  // Event enable mask
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      evtEn <= ifp_pkg::RST_EVT;
    else if (regWr && regAddr == ifp_pkg::ADDR_EVT_EN)
      evtEn <= regWdata[7:0];
  end

  // Level interrupt from enabled sticky events
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(evtStat & evtEn);
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped and write-only addresses read zero
  always_comb
  begin
    next_rdata = 16'h0000;
    if (selFlags)
      next_rdata = {8'h00, flagWord};          // RL1
    else if (selPrio)
      next_rdata = prioReg[prioIdx];           // RL13
    else if (regAddr == ifp_pkg::ADDR_SENSE)
      next_rdata = {8'h00, senseEdge};
    else if (regAddr == ifp_pkg::ADDR_EDGE)
      next_rdata = edgeSelect;
    else if (regAddr == ifp_pkg::ADDR_EVT_STAT)
      next_rdata = {8'h00, evtStat};
    else if (regAddr == ifp_pkg::ADDR_EVT_EN)
      next_rdata = {8'h00, evtEn};
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdata <= 16'h0000;
    else if (regRd)
      regRdata <= next_rdata;
    else
      regRdata <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_rsvd_reads_zero: assert property ( // RL1
    @(posedge sys_clk) disable iff (!arst_n)
    regRd && selFlags |=> regRdata[15:8] == 8'h00)
    else $error("reserved flag bits not zero");

  a_flag_readback: assert property ( // RL3
    @(posedge sys_clk) disable iff (!arst_n)
    regRd && selFlags |=> regRdata[0] == $past(pinFlag[7]) &&
                          regRdata[7] == $past(pinFlag[0]))
    else $error("flag bit order wrong");

  a_edge_sets_flag: assert property ( // RL4
    @(posedge sys_clk) disable iff (!arst_n)
    senseEdge[3] && edgeHit[3] |=> pinFlag[3])
    else $error("edge did not set flag");

  a_sw_clear: assert property ( // RL5
    @(posedge sys_clk) disable iff (!arst_n)
    regRd && selFlags && pinFlag[5] ##1
    regWr && selFlags && !regWdata[2] && !setVec[5] |=> !pinFlag[5])
    else $error("read then write zero did not clear");

  a_keep_unarmed: assert property ( // RL17
    @(posedge sys_clk) disable iff (!arst_n)
    pinFlag[2] && !armed[2] && !hwClr[2] |=> pinFlag[2])
    else $error("flag lost without clear sequence");

  a_level_clear: assert property ( // RL6
    @(posedge sys_clk) disable iff (!arst_n)
    !senseEdge[2] && excTaken[2] && !pinLow[2] |=> !pinFlag[2])
    else $error("level flag not cleared on exception");

  a_edge_exc_clear: assert property ( // RL7
    @(posedge sys_clk) disable iff (!arst_n)
    senseEdge[4] && excTaken[4] && !edgeHit[4] |=> !pinFlag[4])
    else $error("edge flag not cleared on exception");

  a_xfer_clear: assert property ( // RL8
    @(posedge sys_clk) disable iff (!arst_n)
    xferStart[6] && !xferClearInhibit && !setVec[6] |=> !pinFlag[6])
    else $error("transfer start did not clear flag");

  a_prio_write_read: assert property ( // RL9
    @(posedge sys_clk) disable iff (!arst_n)
    regWr && selPrio ##1 regRd && $stable(regAddr) |=>
    regRdata == $past(regWdata, 2))
    else $error("priority register readback wrong");

  a_level_request: assert property ( // RL15
    @(posedge sys_clk) disable iff (!arst_n)
    !senseEdge[2] && prioLive[2] |=> pinRequest[2] == $past(pinLow[2]))
    else $error("level request does not follow pin");

  a_masked_source: assert property ( // RL16
    @(posedge sys_clk) disable iff (!arst_n)
    prioReg[1][3:0] == 4'h0 |=> !pinRequest[7])
    else $error("level zero source requested");

  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ##1 irq == $past(|(evtStat & evtEn)))
    else $error("interrupt does not follow enabled events");

endmodule : ifp_regs

`default_nettype wire

// ### testbench/ifp_far_model.sv
// Model of the exception logic and transfer controller facing the flag block
`timescale 1ns/10ps
`default_nettype none

module ifp_far_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Commands from the bench
  input  wire logic       acceptOn,
  input  wire logic       slowOn,
  input  wire logic [7:0] excCmd,
  input  wire logic [7:0] xferCmd,
  input  wire logic       xferInhib,
  // Block side
  input  wire logic [7:0] pinRequest,
  output logic      [7:0] excTaken,
  output logic      [7:0] xferStart,
  output logic            xferClearInhibit
);
  logic [2:0] coolCnt;
  logic [2:0] holdCnt;

  // Accept the lowest pending pin, slowly if asked, then rest while it drains
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      excTaken <= 8'h00;
      coolCnt  <= 3'h0;
      holdCnt  <= 3'h0;
    end
    else if (coolCnt != 3'h0)
    begin
      excTaken <= excCmd;
      coolCnt  <= coolCnt - 3'h1;
    end
    else if (acceptOn && (|pinRequest) && (!slowOn || holdCnt == 3'h5))
    begin
      excTaken <= pinRequest & (~pinRequest + 8'h01);
      coolCnt  <= 3'h4;
      holdCnt  <= 3'h0;
    end
    else
    begin
      excTaken <= excCmd;
      holdCnt  <= (acceptOn && (|pinRequest)) ? holdCnt + 3'h1 : 3'h0;
    end
  end

  // Transfer starts as one-cycle pulses with their clear-inhibit bit
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xferStart        <= 8'h00;
      xferClearInhibit <= 1'b0;
    end
    else
    begin
      xferStart        <= xferCmd;
      xferClearInhibit <= xferInhib;
    end
  end
endmodule : ifp_far_model

`default_nettype wire

// ### testbench/ifp_regs_test.sv
// Self-checking bench for the request flag and priority register block
`timescale 1ns/10ps
`default_nettype none

module ifp_regs_test;
  logic sys_clk, arst_n, regWr, regRd, irq, xferClearInhibit;
  logic acceptOn, slowOn, xferInhib;
  logic [7:0] regAddr, extRequestPin_n, excTaken, xferStart, pinRequest;
  logic [7:0] excCmd, xferCmd;
  logic [15:0] regWdata, regRdata;
  logic [159:0] priorityLevels;
  int errors, num_checks;

  ifp_regs ifp_regs_inst (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .extRequestPin_n(extRequestPin_n), .excTaken(excTaken), .xferStart(xferStart),
    .xferClearInhibit(xferClearInhibit), .pinRequest(pinRequest),
    .priorityLevels(priorityLevels), .irq(irq));

  ifp_far_model ifp_far_model_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .acceptOn(acceptOn), .slowOn(slowOn), .excCmd(excCmd), .xferCmd(xferCmd),
    .xferInhib(xferInhib), .pinRequest(pinRequest), .excTaken(excTaken),
    .xferStart(xferStart), .xferClearInhibit(xferClearInhibit));

  // 10 MHz clock
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] flagBit(int n);
    return 16'h0001 << (7 - n);
  endfunction : flagBit

  function automatic logic [15:0] fieldVal(int n, logic [3:0] lvl);
    return {12'h000, lvl} << (4 * (3 - n % 4));
  endfunction : fieldVal

  task automatic complete_run();
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Wait edges, then step past the edge so outputs are settled
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wrReg(logic [7:0] a, logic [15:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask : wrReg

  task automatic rdReg(logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask : rdReg

  // Write then read back with no gap between the strobes
  task automatic wrRdReg(logic [7:0] a, logic [15:0] wd, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= wd;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
    regRd    <= 1'b1;
    @(posedge sys_clk);
    regRd    <= 1'b0;
    #1 d = regRdata;
  endtask : wrRdReg

  task automatic chkReg(logic [7:0] a, logic [15:0] exp);
    logic [15:0] d;
    rdReg(a, d);
    check("register", d, exp);
  endtask : chkReg

  // Read the flags, then at once write zero to the pin's flag, ones elsewhere
  task automatic swClear(int n);
    @(posedge sys_clk);
    regAddr  <= ifp_pkg::ADDR_FLAGS;
    regRd    <= 1'b1;
    @(posedge sys_clk);
    regRd    <= 1'b0;
    regWdata <= ~flagBit(n) & 16'h00FF;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask : swClear

  task automatic setPin(int n, logic v);
    @(posedge sys_clk);
    extRequestPin_n[n] <= v;
  endtask : setPin

  task automatic waitReq(int n, logic v);
    int i;
    i = 0;
    while (pinRequest[n] !== v && i < 40)
    begin
      @(posedge sys_clk);
      #1 i++;
    end
  endtask : waitReq

  task automatic pulse(logic [7:0] e, logic [7:0] x, logic inh);
    @(posedge sys_clk);
    excCmd    <= e;
    xferCmd   <= x;
    xferInhib <= inh;
    @(posedge sys_clk);
    excCmd    <= 8'h00;
    xferCmd   <= 8'h00;
    tick(3);
  endtask : pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] v;
    logic [15:0] readBack;
    logic [7:0] pa;
    int n;
    errors = 0;
    num_checks = 0;
    arst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    extRequestPin_n = 8'hFF;
    excCmd = 8'h00;
    xferCmd = 8'h00;
    xferInhib = 1'b0;
    acceptOn = 1'b0;
    slowOn = 1'b0;
    v = 16'($urandom(32'hE493));
    tick(10);
    arst_n <= 1'b1;
    // Reset values and priority read/write
    chkReg(ifp_pkg::ADDR_FLAGS, 16'h0000);
    for (int k = 0; k < 10; k++)
    begin
      pa = ifp_pkg::ADDR_PRIO_BASE + 8'(k);
      chkReg(pa, 16'h0000);
      v = 16'($urandom);
      wrRdReg(pa, v, readBack);
      check("register", readBack, v);
      check("levels", priorityLevels[16*k +: 16], v);
      wrReg(pa, 16'h0000);
    end
    wrReg(ifp_pkg::ADDR_FLAGS, 16'h00FF);
    chkReg(ifp_pkg::ADDR_FLAGS, 16'h0000);
    chkReg(8'h40, 16'h0000);
    // Every edge select code on a random pin
    wrReg(ifp_pkg::ADDR_SENSE, 16'h00FF);
    for (int c = 0; c < 4; c++)
    begin
      n = $urandom % 8;
      wrReg(ifp_pkg::ADDR_EDGE, 16'(c) << (14 - 2 * n));
      setPin(n, 1'b0);
      tick(3);
      chkReg(ifp_pkg::ADDR_FLAGS, (c == 0 || c == 2) ? flagBit(n) : 16'h0000);
      check("request", {8'h00, pinRequest}, 16'h0000);
      swClear(n);
      chkReg(ifp_pkg::ADDR_FLAGS, 16'h0000);
      setPin(n, 1'b1);
      tick(3);
      chkReg(ifp_pkg::ADDR_FLAGS, (c == 1 || c == 2) ? flagBit(n) : 16'h0000);
      swClear(n);
    end
    // Clearing needs a read of one first
    wrReg(ifp_pkg::ADDR_EDGE, 16'h0000);
    setPin(3, 1'b0);
    tick(3);
    wrReg(ifp_pkg::ADDR_FLAGS, 16'h0000);
    chkReg(ifp_pkg::ADDR_FLAGS, flagBit(3));
    wrReg(ifp_pkg::ADDR_FLAGS, flagBit(3));
    chkReg(ifp_pkg::ADDR_FLAGS, flagBit(3));
    wrReg(ifp_pkg::ADDR_FLAGS, 16'h0000);
    chkReg(ifp_pkg::ADDR_FLAGS, 16'h0000);
    setPin(3, 1'b1);
    // Event interrupt raised, masked and cleared
    wrReg(ifp_pkg::ADDR_EVT_CLEAR, 16'h00FF);
    wrReg(ifp_pkg::ADDR_EVT_EN, 16'h0020);
    tick(1);
    check("irq", {15'h0000, irq}, 16'h0000);
    setPin(5, 1'b0);
    tick(3);
    check("irq", {15'h0000, irq}, 16'h0001);
    chkReg(ifp_pkg::ADDR_EVT_STAT, 16'h0020);
    wrReg(ifp_pkg::ADDR_EVT_EN, 16'h0000);
    tick(2);
    check("irq", {15'h0000, irq}, 16'h0000);
    wrReg(ifp_pkg::ADDR_EVT_EN, 16'h0020);
    tick(2);
    check("irq", {15'h0000, irq}, 16'h0001);
    wrReg(ifp_pkg::ADDR_EVT_CLEAR, 16'h0020);
    tick(2);
    check("irq", {15'h0000, irq}, 16'h0000);
    chkReg(ifp_pkg::ADDR_EVT_STAT, 16'h0000);
    swClear(5);
    setPin(5, 1'b1);
    // Exception acceptance clears edge flags, prompt and slow
    for (int i = 0; i < 4; i++)
    begin
      n = (i == 0) ? 4 : int'($urandom % 8);
      pa = ifp_pkg::ADDR_PRIO_BASE + 8'(n / 4);
      wrReg(pa, fieldVal(n, 4'($urandom % 15 + 1)));
      acceptOn <= 1'b1;
      slowOn <= i[0];
      setPin(n, 1'b0);
      waitReq(n, 1'b1);
      check("request", {15'h0000, pinRequest[n]}, 16'h0001);
      waitReq(n, 1'b0);
      check("request", {15'h0000, pinRequest[n]}, 16'h0000);
      chkReg(ifp_pkg::ADDR_FLAGS, 16'h0000);
      acceptOn <= 1'b0;
      setPin(n, 1'b1);
      wrReg(pa, 16'h0000);
    end
    // Transfer start clears unless inhibited
    setPin(6, 1'b0);
    tick(3);
    pulse(8'h00, 8'h40, 1'b1);
    chkReg(ifp_pkg::ADDR_FLAGS, flagBit(6));
    pulse(8'h00, 8'h40, 1'b0);
    chkReg(ifp_pkg::ADDR_FLAGS, 16'h0000);
    setPin(6, 1'b1);
    // Low level sense mode
    wrReg(ifp_pkg::ADDR_SENSE, 16'h0000);
    wrReg(ifp_pkg::ADDR_PRIO_BASE, fieldVal(2, 4'h9));
    setPin(2, 1'b0);
    tick(3);
    check("request", {8'h00, pinRequest}, 16'h0004);
    pulse(8'h04, 8'h00, 1'b0);
    chkReg(ifp_pkg::ADDR_FLAGS, flagBit(2));
    setPin(2, 1'b1);
    tick(3);
    check("request", {8'h00, pinRequest}, 16'h0000);
    pulse(8'h04, 8'h00, 1'b0);
    chkReg(ifp_pkg::ADDR_FLAGS, 16'h0000);
    wrReg(ifp_pkg::ADDR_PRIO_BASE, 16'h0000);
    setPin(2, 1'b0);
    tick(3);
    check("request", {8'h00, pinRequest}, 16'h0000);
    setPin(2, 1'b1);
    complete_run();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    tick(20000);
    errors++;
    complete_run();
  end
endmodule : ifp_regs_test

`default_nettype wire
